// [design/bsc_ctrl.sv]
// Boundary-scan chain control, test-port disable and test-reset flag
`timescale 1ns/10ps
// Summary of operation
// RULE1: Reset pin gets observe-only cell, never driven
// RULE2: Port active when fuse set and disable clear
// RULE3: Disable bit changes only on timed double write
// RULE4: Software keeps disable bit while debugging
// RULE5: Test reset sets status flag bit four
// RULE6: Flag cleared by power-on or zero write
// RULE7: Bit zero shifts in first, out first
// RULE8: Chain follows pin order, ports A K reversed; port F is reversed as well here
// RULE9: Analog cells would take top chain positions
// RULE10: Data cell first flop, control cell second
// RULE11: Port F pins four to seven unscanned
// RULE12: Reset cell sits at position 110
// RULE13: Chain order fixed from 164 to 0
// RULE14: Device held reset while reset register high
// RULE15: Missed second write keeps old disable value
// RULE16: Reserved bits read zero, writes ignored
module bsc_ctrl #(
    parameter int NPINS = bsc_pkg::PIN_COUNT
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             other_reset_i,
    input  wire logic             fuse_enable_i,
    // Register port
    input  wire logic [7:0]       addr_i,
    input  wire logic [7:0]       wdata_i,
    input  wire logic             wr_i,
    input  wire logic             rd_i,
    output logic      [7:0]       rdata_o,
    // Test access pins and controller state
    input  wire logic             tck_i,
    input  wire logic             tdi_i,
    output logic                  tdo_o,
    output logic                  tdo_oe_o,
    input  wire logic             tap_capture_i,
    input  wire logic             tap_shift_i,
    input  wire logic             tap_update_i,
    input  wire logic             sel_chain_i,
    input  wire logic             sel_reset_i,
    input  wire logic             extest_i,
    // Reset pin, observed only
    input  wire logic             reset_pin_n_i,
    // Port pins
    input  wire logic [NPINS-1:0] pin_in_i,
    input  wire logic [NPINS-1:0] core_out_i,
    input  wire logic [NPINS-1:0] core_oe_i,
    input  wire logic [NPINS-1:0] core_pullup_i,
    output logic      [NPINS-1:0] pin_out_o,
    output logic      [NPINS-1:0] pin_oe_o,
    output logic      [NPINS-1:0] pin_pullup_o,
    // Core-side controls
    output logic                  test_port_active_o,
    output logic                  core_reset_o,
    output logic                  vector_table_select_o,
    output logic                  vector_change_unlock_o
);
    localparam int NCTL = 9;
    localparam int NSYN = NCTL + NPINS;
    localparam int LEN  = bsc_pkg::CHAIN_LEN;

    // Synchronisers for everything arriving from the test clock or pins
    logic [NSYN-1:0] sync1_reg;
    logic [NSYN-1:0] sync2_reg;
    logic [NSYN-1:0] async_in;

    assign async_in = {pin_in_i, tck_i, tdi_i, tap_capture_i, tap_shift_i,
                       tap_update_i, sel_chain_i, sel_reset_i, extest_i, reset_pin_n_i};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= async_in;
            sync2_reg <= sync1_reg;
        end
    end

    wire logic [NPINS-1:0] pin_s;
    wire logic             tck_s;
    wire logic             tdi_s;
    wire logic             cap_s;
    wire logic             shift_s;
    wire logic             upd_s;
    wire logic             selc_s;
    wire logic             selr_s;
    wire logic             ext_s;
    wire logic             rstpin_s;

    assign pin_s    = sync2_reg[NSYN-1:NCTL];
    assign tck_s    = sync2_reg[8];
    assign tdi_s    = sync2_reg[7];
    assign cap_s    = sync2_reg[6];
    assign shift_s  = sync2_reg[5];
    assign upd_s    = sync2_reg[4];
    assign selc_s   = sync2_reg[3];
    assign selr_s   = sync2_reg[2];
    assign ext_s    = sync2_reg[1];
    assign rstpin_s = sync2_reg[0];

    // Edges of the test clock, seen from the system clock
    logic tck_prev_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tck_prev_reg <= 1'b0;
        end else begin
            tck_prev_reg <= tck_s;
        end
    end

    wire logic tck_rise;
    wire logic tck_fall;

    assign tck_rise = tck_s & ~tck_prev_reg;
    assign tck_fall = ~tck_s & tck_prev_reg;

    // Control register
    logic       disable_reg;
    logic       pullup_off_reg;
    logic       vecsel_reg;
    logic       vecunlk_reg;
    logic [2:0] arm_cnt_reg;
    logic       arm_val_reg;
    logic       test_reset_flag_reg;
    logic       reset_data_reg;

    wire logic port_active;
    wire logic wr_ctl;
    wire logic wr_sts;
    wire logic new_disable;
    wire logic second_write;
    wire logic ctl_reset;

    assign port_active  = fuse_enable_i & ~disable_reg; // RULE2
    assign wr_ctl       = wr_i & (addr_i == bsc_pkg::ADDR_CONTROL);
    assign wr_sts       = wr_i & (addr_i == bsc_pkg::ADDR_STATUS);
    assign new_disable  = wdata_i[bsc_pkg::CTL_DISABLE_BIT];
    // A second matching write inside the window commits the value
    assign second_write = wr_ctl & (arm_cnt_reg != 3'h0) & (new_disable == arm_val_reg); // RULE3
    assign ctl_reset    = rst_i | other_reset_i | core_reset_o;

    // Software must leave the disable bit alone during debug; nothing here guards it
    always_ff @(posedge clk_i) begin
        if (ctl_reset) begin
            disable_reg <= bsc_pkg::CONTROL_RST[bsc_pkg::CTL_DISABLE_BIT];
            arm_cnt_reg <= 3'h0;
            arm_val_reg <= 1'b0;
        end else if (second_write) begin
            disable_reg <= new_disable; // RULE3
            arm_cnt_reg <= 3'h0;
        end else if (wr_ctl) begin
            arm_cnt_reg <= bsc_pkg::TIMED_WINDOW_CYC;
            arm_val_reg <= new_disable;
        end else if (arm_cnt_reg != 3'h0) begin
            // Window runs out with the old value kept
            arm_cnt_reg <= arm_cnt_reg - 3'h1; // RULE15
        end
    end

    // Plain control bits take every write; reserved bits are not stored
    always_ff @(posedge clk_i) begin
        if (ctl_reset) begin
            pullup_off_reg <= bsc_pkg::CONTROL_RST[bsc_pkg::CTL_PULLUP_BIT];
            vecsel_reg     <= bsc_pkg::CONTROL_RST[bsc_pkg::CTL_VECSEL_BIT];
            vecunlk_reg    <= bsc_pkg::CONTROL_RST[bsc_pkg::CTL_VECUNLK_BIT];
        end else if (wr_ctl) begin
            pullup_off_reg <= wdata_i[bsc_pkg::CTL_PULLUP_BIT]; // RULE16
            vecsel_reg     <= wdata_i[bsc_pkg::CTL_VECSEL_BIT];
            vecunlk_reg    <= wdata_i[bsc_pkg::CTL_VECUNLK_BIT];
        end
    end

    // Test reset flag: only power-on reset or a zero write clears it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            test_reset_flag_reg <= bsc_pkg::TESTRST_RST; // RULE6
        end else if (core_reset_o) begin
            test_reset_flag_reg <= 1'b1; // RULE5
        end else if (wr_sts && !wdata_i[bsc_pkg::STS_TESTRST_BIT]) begin
            test_reset_flag_reg <= 1'b0; // RULE6
        end
    end

    // Read port, data one cycle after the strobe
    wire logic [7:0] ctl_view;
    wire logic [7:0] sts_view;
    wire logic [7:0] rd_mux;

    assign ctl_view = {disable_reg, 2'b00, pullup_off_reg, 2'b00, vecsel_reg, vecunlk_reg}; // RULE16
    assign sts_view = {3'b000, test_reset_flag_reg, 4'h0}; // RULE16
    assign rd_mux   = (addr_i == bsc_pkg::ADDR_CONTROL) ? ctl_view :
                      (addr_i == bsc_pkg::ADDR_STATUS)  ? sts_view : 8'h00;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            rdata_o <= rd_mux;
        end else begin
            rdata_o <= 8'h00;
        end
    end

    // Chain strobes, all gated by the port enable
    wire logic scan_capture;
    wire logic scan_shift;
    wire logic scan_update;
    wire logic rreg_shift;

    assign scan_capture = port_active & tck_rise & cap_s & selc_s;
    assign scan_shift   = port_active & tck_rise & shift_s & selc_s; // RULE7
    assign scan_update  = port_active & tck_fall & upd_s & selc_s;
    assign rreg_shift   = port_active & tck_rise & shift_s & selr_s;

    // Capture and update maps
    wire logic [LEN-1:0]   cap_vec;
    wire logic [LEN-1:0]   upd_vec;
    wire logic [NPINS-1:0] bs_drv;
    wire logic [NPINS-1:0] bs_oe;
    wire logic             chain_tdo;

    // Reset pin only feeds capture; its update bit goes nowhere
    assign cap_vec[bsc_pkg::RESET_CELL_POS] = rstpin_s; // RULE1 RULE12

    // Mixed-signal pins carry no cells, so nothing is placed above the pin cells
    for (genvar s = 0; s < bsc_pkg::PIN_SLOTS; s++) begin : g_slot // RULE9
        localparam int P = bsc_pkg::slot_pin(s); // RULE8 RULE13
        localparam int C = bsc_pkg::ctrl_pos(s);
        assign cap_vec[C + 1] = pin_s[P]; // RULE10
        assign cap_vec[C]     = core_oe_i[P]; // RULE10
        assign bs_drv[P]      = upd_vec[C + 1];
        assign bs_oe[P]       = upd_vec[C];
    end

    for (genvar p = 0; p < NPINS; p++) begin : g_nocell
        if (!bsc_pkg::CELL_MASK[p]) begin : g_tap
            assign bs_drv[p] = 1'b0; // RULE11
            assign bs_oe[p]  = 1'b0;
        end
    end

    bsc_chain #(
        .LEN           (LEN)
    ) u_chain (
        .clk_i         (clk_i),
        .rst_i         (rst_i),
        .capture_i     (scan_capture),
        .shift_i       (scan_shift),
        .update_i      (scan_update),
        .tdi_i         (tdi_s),
        .capture_vec_i (cap_vec),
        .update_vec_o  (upd_vec),
        .tdo_o         (chain_tdo)
    );

    // One-bit reset data register, shifted under the reset instruction
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reset_data_reg <= 1'b0;
        end else if (rreg_shift) begin
            reset_data_reg <= tdi_s;
        end
    end

    // Unlatched reset register: core reset follows its contents directly, but only while the port is active
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            core_reset_o <= 1'b0;
        end else begin
            core_reset_o <= reset_data_reg & port_active; // RULE14
        end
    end

    // Serial output moves on the falling test-clock edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tdo_o    <= 1'b0;
            tdo_oe_o <= 1'b0;
        end else if (tck_fall) begin
            tdo_o    <= selr_s ? reset_data_reg : chain_tdo; // RULE7
            tdo_oe_o <= port_active & shift_s & (selc_s | selr_s);
        end
    end

    // Pin drivers: update latches win only under the external-test instruction
    wire logic             ext_on;
    wire logic [NPINS-1:0] drv_sel;

    assign ext_on  = port_active & ext_s & selc_s;
    // Pins without a cell are held quiet too, so the core cannot fight the tester
    assign drv_sel = ext_on ? '1 : '0;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_out_o    <= '0;
            pin_oe_o     <= '0;
            pin_pullup_o <= '0;
        end else begin
            pin_out_o    <= (bs_drv & drv_sel) | (core_out_i & ~drv_sel);
            pin_oe_o     <= (bs_oe & drv_sel) | (core_oe_i & ~drv_sel);
            // Pull-ups are off while the chain is the selected path
            pin_pullup_o <= (pullup_off_reg || (port_active && selc_s)) ? '0 : core_pullup_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            test_port_active_o     <= 1'b0;
            vector_table_select_o  <= 1'b0;
            vector_change_unlock_o <= 1'b0;
        end else begin
            test_port_active_o     <= port_active; // RULE2
            vector_table_select_o  <= vecsel_reg;
            vector_change_unlock_o <= vecunlk_reg;
        end
    end
endmodule

// [design/bsc_pkg.sv]
// Constants, register map and chain layout of the boundary-scan control block
package bsc_pkg;

    // Register offsets on the plain register port
    localparam logic [7:0] ADDR_STATUS  = 8'h34;
    localparam logic [7:0] ADDR_CONTROL = 8'h35;

    // Field positions
    localparam int CTL_DISABLE_BIT  = 7;
    localparam int CTL_PULLUP_BIT   = 4;
    localparam int CTL_VECSEL_BIT   = 1;
    localparam int CTL_VECUNLK_BIT  = 0;
    localparam int STS_TESTRST_BIT  = 4;

    // Values after reset
    localparam logic [7:0] CONTROL_RST  = 8'h00;
    localparam logic       TESTRST_RST  = 1'b0;

    // Second write of the timed sequence must land within this many cycles
    localparam logic [2:0] TIMED_WINDOW_CYC = 3'h4;
    localparam int         SYNC_STAGES      = 2;

    // Chain layout
    localparam int CHAIN_LEN      = 165;
    localparam int PIN_SLOTS      = 82;
    localparam int RESET_CELL_POS = 110;
    localparam int PIN_COUNT      = 88;

    // Pin index is port*8+bit, ports in order A B C D E F G H J K L
    localparam int PORT_A = 0;
    localparam int PORT_B = 1;
    localparam int PORT_C = 2;
    localparam int PORT_D = 3;
    localparam int PORT_E = 4;
    localparam int PORT_F = 5;
    localparam int PORT_G = 6;
    localparam int PORT_H = 7;
    localparam int PORT_J = 8;
    localparam int PORT_K = 9;
    localparam int PORT_L = 10;

    // Pins that own a cell; F4..F7 serve the test port, G6/G7 do not exist
    localparam logic [87:0] CELL_MASK = 88'hff_ff_ff_ff_3f_0f_ff_ff_ff_ff_ff;

    // Chain runs from slot 0 upward through these runs of pins
    localparam int SEG_NUM = 16;
    localparam int SEG_START [SEG_NUM] = '{
        PORT_F*8+0, PORT_K*8+0, PORT_J*8+7, PORT_A*8+0,
        PORT_G*8+2, PORT_J*8+6, PORT_C*8+7, PORT_G*8+1,
        PORT_D*8+7, PORT_L*8+7, PORT_G*8+4, PORT_H*8+7,
        PORT_B*8+7, PORT_H*8+6, PORT_E*8+7, PORT_G*8+5};
    localparam int SEG_LEN [SEG_NUM] = '{4, 8, 1, 8, 1, 7, 8, 2, 8, 8, 2, 1, 8, 7, 8, 1};
    localparam bit SEG_UP  [SEG_NUM] = '{1, 1, 1, 1, 1, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0};

    // Pin served by a chain slot
    function automatic int slot_pin(input int slot);
        int base;
        int res;
        base = 0;
        res  = 0;
        for (int i = 0; i < SEG_NUM; i++) begin
            if (slot >= base && slot < base + SEG_LEN[i]) begin
                res = SEG_UP[i] ? SEG_START[i] + (slot - base) : SEG_START[i] - (slot - base);
            end
            base = base + SEG_LEN[i];
        end
        return res;
    endfunction

    // Control cell position; the data cell is one above it
    function automatic int ctrl_pos(input int slot);
        return (slot < RESET_CELL_POS / 2) ? 2 * slot : 2 * slot + 1;
    endfunction

endpackage

// [design/bsc_chain.sv]
// Boundary-scan shift register with capture and update stages
`timescale 1ns/10ps
module bsc_chain #(
    parameter int LEN = bsc_pkg::CHAIN_LEN
) (
    input  wire logic           clk_i,
    input  wire logic           rst_i,
    input  wire logic           capture_i,
    input  wire logic           shift_i,
    input  wire logic           update_i,
    input  wire logic           tdi_i,
    input  wire logic [LEN-1:0] capture_vec_i,
    output logic      [LEN-1:0] update_vec_o,
    output logic                tdo_o
);
    logic [LEN-1:0] shift_reg;
    logic [LEN-1:0] shift_next;

    // Serial data enters at the top and leaves from bit 0
    assign shift_next = shift_i ? {tdi_i, shift_reg[LEN-1:1]} : capture_vec_i;
    assign tdo_o      = shift_reg[0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shift_reg <= '0;
        end else if (shift_i || capture_i) begin
            shift_reg <= shift_next;
        end
    end

    // Update latches hold still while the chain shifts
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            update_vec_o <= '0;
        end else if (update_i) begin
            update_vec_o <= shift_reg;
        end
    end
endmodule

// [verification/bsc_ctrl_sva.sv]
// Port checks for the boundary-scan control block
`timescale 1ns/10ps
module bsc_chk (
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       fuse_enable_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic       wr_i,
    input wire logic       rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic       tck_i,
    input wire logic       tdo_o,
    input wire logic       test_port_active_o,
    input wire logic       core_reset_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire rd_ctl = rd_i && addr_i == 8'h35;
    wire rd_sts = rd_i && addr_i == 8'h34;
    wire rd_unm = rd_i && !rd_ctl && !rd_sts;
    wire wr_dis = wr_i && addr_i == 8'h35 && wdata_i[7];

    property p_unm;
        $past(rd_unm) |-> rdata_o == 8'h00;
    endproperty
    a_unm: assert property (p_unm)
        else $error("unmapped read not zero");
    property p_ctl;
        $past(rd_ctl) |-> (rdata_o & 8'h6c) == 8'h00;
    endproperty
    a_ctl: assert property (p_ctl)
        else $error("control reserved bits not zero");
    property p_sts;
        $past(rd_sts) |-> (rdata_o & 8'hef) == 8'h00;
    endproperty
    a_sts: assert property (p_sts)
        else $error("status reserved bits not zero");
    property p_fuse;
        !fuse_enable_i |=> !test_port_active_o;
    endproperty
    a_fuse: assert property (p_fuse)
        else $error("port active with fuse off");
    // Falling activity with the fuse on needs the confirming write two cycles back
    property p_fall;
        $fell(test_port_active_o) && $past(fuse_enable_i) |-> $past(wr_dis, 2);
    endproperty
    a_fall: assert property (p_fall)
        else $error("port disabled without a write");
    property p_tdo;
        $changed(tdo_o) |-> !$past(tck_i) && !$past(tck_i, 2);
    endproperty
    a_tdo: assert property (p_tdo)
        else $error("serial output moved outside a falling edge");
    property p_rstoff;
        !test_port_active_o [*2] |=> !core_reset_o;
    endproperty
    a_rstoff: assert property (p_rstoff)
        else $error("core reset from a disabled port");
    property p_flag;
        rd_sts && core_reset_o && $past(core_reset_o) |=> rdata_o[4];
    endproperty
    a_flag: assert property (p_flag)
        else $error("test reset flag not set");
endmodule

bind bsc_ctrl bsc_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .fuse_enable_i(fuse_enable_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .tck_i(tck_i), .tdo_o(tdo_o), .test_port_active_o(test_port_active_o),
    .core_reset_o(core_reset_o));

// [verification/bsc_tester.sv]
// Stand-in for an external boundary-scan tester driving the test clock
`timescale 1ns/10ps
module bsc_tester (
    input  wire logic tdo_i,
    input  wire logic tdo_oe_i,
    output logic      tck_o = 1'b0,
    output logic      tdi_o = 1'b1,
    output logic      capture_o = 1'b0,
    output logic      shift_o = 1'b0,
    output logic      update_o = 1'b0
);
    // Serial output enable seen at every shift bit of the last frame
    logic oe_all;

    // One test clock period of 125 ns; the output is taken just before the rise
    task automatic pulse(input logic din, output logic dout);
        tdi_o <= din;
        #62.5;
        dout = tdo_i;
        tck_o <= 1'b1;
        #62.5;
        tck_o <= 1'b0;
    endtask

    // Controller inputs only move after a falling edge; clock idles low between frames
    task automatic scan(input logic cap, input logic [164:0] din, input int n,
                        output logic [164:0] dout);
        logic unused;
        dout = '0;
        if (cap) begin
            capture_o <= 1'b1;
            pulse(1'b1, unused);
            capture_o <= 1'b0;
        end
        shift_o <= 1'b1;
        oe_all = 1'b1;
        for (int i = 0; i < n; i++) begin
            pulse(din[i], dout[i]);
            oe_all &= tdo_oe_i;
        end
        shift_o <= 1'b0;
        update_o <= 1'b1;
        pulse(1'b1, unused);
        // Latches load on the falling edge, so the update state outlasts it
        #62.5;
        update_o <= 1'b0;
        // Data line is driven back high once the frame ends
        tdi_o <= 1'b1;
    endtask
endmodule

// [verification/tb_top.sv]
// Self-checking bench for the boundary-scan control block
`timescale 1ns/10ps
module tb_top;
    logic         clk_i = 1'b0, rst_i = 1'b1, other_reset_i = 1'b0, fuse_enable_i = 1'b1;
    logic         wr_i = 1'b0, rd_i = 1'b0, sel_chain_i = 1'b0, sel_reset_i = 1'b0;
    logic         extest_i = 1'b0, reset_pin_n_i = 1'b1;
    logic [7:0]   addr_i = 8'h00, wdata_i = 8'h00, rdata_o;
    logic         tck_i, tdi_i, tap_capture_i, tap_shift_i, tap_update_i, tdo_o, tdo_oe_o;
    logic         test_port_active_o, core_reset_o, vector_table_select_o, vector_change_unlock_o;
    logic [87:0]  pin_in_i = 88'h3c_a5_96_0f_f0_69_c3_5a_e1_1e_87;
    logic [87:0]  core_oe_i = 88'h5a_0f_c3_e1_96_3c_87_a5_1e_f0_69;
    logic [87:0]  core_out_i = 88'h0, core_pullup_i = '1, pin_out_o, pin_oe_o, pin_pullup_o;
    logic [87:0]  eo, ee;
    logic [164:0] scan_in, got, exp;
    int           mismatches = 0, checks = 0, pin_at [165];
    bit           is_data [165];

    always #5 clk_i = ~clk_i;

    bsc_ctrl dut (.clk_i, .rst_i, .other_reset_i, .fuse_enable_i, .addr_i, .wdata_i, .wr_i,
        .rd_i, .rdata_o, .tck_i, .tdi_i, .tdo_o, .tdo_oe_o, .tap_capture_i, .tap_shift_i,
        .tap_update_i, .sel_chain_i, .sel_reset_i, .extest_i, .reset_pin_n_i, .pin_in_i,
        .core_out_i, .core_oe_i, .core_pullup_i, .pin_out_o, .pin_oe_o, .pin_pullup_o,
        .test_port_active_o, .core_reset_o, .vector_table_select_o, .vector_change_unlock_o);
    bsc_tester u_tst (.tdo_i(tdo_o), .tdo_oe_i(tdo_oe_o), .tck_o(tck_i), .tdi_o(tdi_i),
        .capture_o(tap_capture_i), .shift_o(tap_shift_i), .update_o(tap_update_i));

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chkv(input string nm, input logic [164:0] e, input logic [164:0] g);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    // n above one gives back-to-back writes
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input int n = 1);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        repeat (n) @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        chk8(nm, e, rdata_o);
    endtask

    task automatic rst_reg(input logic b);
        @(posedge clk_i);
        sel_reset_i <= 1'b1;
        u_tst.scan(1'b0, 165'(b), 1, got);
        repeat (8) @(posedge clk_i);
        sel_reset_i <= 1'b0;
    endtask

    // Pin of each chain position, runs listed from the top; A, K and F count down
    function automatic void build_map();
        int st[17] = '{53, 32, 56, 8, 63, 51, -1, 80, 24, 48, 16, 64, 50, 7, 71, 79, 43};
        int ln[17] = '{1, 8, 7, 8, 1, 2, 1, 8, 8, 2, 8, 7, 1, 8, 1, 8, 4};
        int pos;
        pos = 164;
        for (int r = 0; r < 17; r++) begin
            for (int k = 0; k < ln[r]; k++) begin
                if (st[r] < 0) begin
                    pin_at[pos] = -1;
                    pos--;
                end else begin
                    pin_at[pos] = (r == 13 || r >= 15) ? st[r] - k : st[r] + k;
                    pin_at[pos - 1] = pin_at[pos];
                    is_data[pos] = 1'b1;
                    pos -= 2;
                end
            end
        end
    endfunction

    task automatic t_regs();
        rd(8'h35, 8'h00, "control reset");
        rd(8'h34, 8'h00, "status reset");
        rd(8'h36, 8'h00, "unmapped");
        wr(8'h35, 8'hff);
        repeat (3) @(posedge clk_i);
        wr(8'h35, 8'hff);
        rd(8'h35, 8'h13, "late second write");
        repeat (6) @(posedge clk_i);
        wr(8'h35, 8'hff);
        repeat (2) @(posedge clk_i);
        wr(8'h35, 8'hff);
        rd(8'h35, 8'h93, "timed pair");
        chkv("vector bits", 165'(2'b11), 165'({vector_table_select_o, vector_change_unlock_o}));
        chkv("port active", 165'(1'b0), 165'(test_port_active_o));
        rst_reg(1'b1);
        chkv("core reset", 165'(1'b0), 165'(core_reset_o));
        wr(8'h35, 8'h00, 2);
        rd(8'h35, 8'h00, "clear pair");
        chkv("port active", 165'(1'b1), 165'(test_port_active_o));
        @(posedge clk_i);
        fuse_enable_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        chkv("fuse off", 165'(1'b0), 165'(test_port_active_o));
        fuse_enable_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        $display("registers done");
    endtask

    task automatic t_chain();
        @(posedge clk_i);
        sel_chain_i <= 1'b1;
        extest_i <= 1'b1;
        reset_pin_n_i <= 1'b0;
        scan_in = {33{5'b10110}};
        eo = '0;
        ee = '0;
        u_tst.scan(1'b1, scan_in, 165, got);
        for (int p = 0; p < 165; p++) begin
            exp[p] = pin_at[p] < 0 ? reset_pin_n_i
                   : is_data[p] ? pin_in_i[pin_at[p]] : core_oe_i[pin_at[p]];
            if (pin_at[p] >= 0 && is_data[p]) eo[pin_at[p]] = scan_in[p];
            if (pin_at[p] >= 0 && !is_data[p]) ee[pin_at[p]] = scan_in[p];
        end
        chkv("captured chain", exp, got);
        repeat (10) @(posedge clk_i);
        chkv("pin drive", 165'(eo), 165'(pin_out_o));
        chkv("pin enable", 165'(ee), 165'(pin_oe_o));
        chkv("tdo enable", 165'(1'b1), 165'(u_tst.oe_all));
        chkv("tdo enable idle", 165'(1'b0), 165'(tdo_oe_o));
        chkv("pull-ups off", 165'(1'b0), 165'(pin_pullup_o));
        extest_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        // Sample mode leaves the pins to the core
        chkv("sample keeps core", 165'(core_oe_i), 165'(pin_oe_o));
        sel_chain_i <= 1'b0;
        reset_pin_n_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        chkv("pull-ups back", 165'(core_pullup_i), 165'(pin_pullup_o));
        $display("chain done");
    endtask

    task automatic t_reset();
        rst_reg(1'b1);
        chkv("core reset", 165'(1'b1), 165'(core_reset_o));
        rd(8'h34, 8'h10, "flag while held");
        rst_reg(1'b0);
        chkv("core reset", 165'(1'b0), 165'(core_reset_o));
        @(posedge clk_i);
        other_reset_i <= 1'b1;
        @(posedge clk_i);
        other_reset_i <= 1'b0;
        rd(8'h34, 8'h10, "flag after other reset");
        wr(8'h34, 8'hef);
        rd(8'h34, 8'h00, "flag cleared");
        rst_reg(1'b1);
        rst_reg(1'b0);
        rd(8'h34, 8'h10, "flag again");
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(8'h34, 8'h00, "flag after power-on");
        $display("reset done");
    endtask

    initial begin
        build_map();
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        // Disable bit left alone while the tester works the port
        t_chain();
        t_reset();
        complete_run();
    end

    // Roughly ten times the expected run
    initial begin
        #300000;
        mismatches++;
        complete_run();
    end
endmodule
